// ===== hw/ast_pkg.sv
// Constants shared by the serial transceiver design files.
// Assumes a 32-bit AXI4-Lite register window of four words.
package ast_pkg;

	// ------------------------------------------------------------
	// Register byte offsets
	// ------------------------------------------------------------
	localparam logic [3:0] OFS_CTL0 = 4'h0;
	localparam logic [3:0] OFS_CTL1 = 4'h4;
	localparam logic [3:0] OFS_STAT = 4'h8;
	localparam logic [3:0] OFS_DATA = 4'hc;

	// ------------------------------------------------------------
	// Control register 1 field positions
	// ------------------------------------------------------------
	localparam int C_TE = 0;
	localparam int C_RE = 1;
	localparam int C_PE = 2;
	localparam int C_PODD = 3;
	localparam int C_NINE = 4;
	localparam int C_ILONG = 5;
	localparam int C_WMARK = 6;
	localparam int C_SLEEP = 7;
	localparam int C_BRK = 8;
	localparam int C_LOOP = 9;
	localparam int C_OD = 10;
	localparam int C_TIE = 11;
	localparam int C_TX_DONE_IRQ_EN = 12;
	localparam int C_RIE = 13;
	localparam int C_IDLE_IRQ_EN = 14;
	localparam int CTL1_W = 15;

	// ------------------------------------------------------------
	// Status register field positions
	// ------------------------------------------------------------
	localparam int S_PF = 0;
	localparam int S_FE = 1;
	localparam int S_NF = 2;
	localparam int S_OR = 3;
	localparam int S_IDLE = 4;
	localparam int S_RX_BUFFER_FULL_FLAG = 5;
	localparam int S_TC = 6;
	localparam int S_TX_BUFFER_EMPTY_FLAG = 7;
	localparam int STAT_W = 8;

	// ------------------------------------------------------------
	// Reset values and timing counts
	// ------------------------------------------------------------
	localparam logic [12:0] CTL0_RST = 13'h0000;
	localparam logic [CTL1_W-1:0] CTL1_RST = 15'h0000;
	localparam logic [3:0] SUB_LAST = 4'hf;
	localparam logic [3:0] SMP_A = 4'h7;
	localparam logic [3:0] SMP_B = 4'h8;
	localparam logic [3:0] SMP_C = 4'h9;
	localparam logic [7:0] IDLE_T10 = 8'ha0;
	localparam logic [7:0] IDLE_T11 = 8'hb0;
	localparam logic [3:0] LEN10 = 4'ha;
	localparam logic [3:0] LEN11 = 4'hb;
	localparam logic [1:0] RESP_OK = 2'h0;
	localparam logic [1:0] RESP_ERR = 2'h2;

	typedef enum logic [1:0] {
		TX_OFF = 2'b00,
		TX_MARK = 2'b01,
		TX_SHIFT = 2'b10
	} ast_tx_type;

	typedef enum logic [1:0] {
		RX_WAIT = 2'b00,
		RX_START = 2'b01,
		RX_BITS = 2'b10
	} ast_rx_type;

endpackage

// ===== hw/ast_tick_sync.sv
// Receive pin synchroniser and 16x sample-rate generator.
// Assumes rx_pin is asynchronous to aclk.
`timescale 1ns/10ps
`default_nettype none
module ast_tick_sync (
	input wire logic aclk, // System clock
	input wire logic aresetn, // Synchronous reset, low
	input wire logic ce, // Clock enable
	input wire logic rx_pin, // Raw receive pin
	input wire logic [12:0] baud_divisor, // Rate divisor
	output logic rx_sync, // Synchronised pin
	output logic tick // 16x sample strobe
);
	logic rx_meta;
	logic [13:0] cnt;
	wire [13:0] last = {baud_divisor, 1'b0} - 14'h0001;
	wire run = (baud_divisor != 13'h0000);

	// ------------------------------------------------------------
	// Two-stage synchroniser
	// ------------------------------------------------------------
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			rx_meta <= 1'b1;
			rx_sync <= 1'b1;
		end
		else if (ce)
		begin
			rx_meta <= rx_pin;
			rx_sync <= rx_meta;
		end
	end

	// ------------------------------------------------------------
	// One tick every two divisor counts: 32 x divisor per bit
	// ------------------------------------------------------------
	always_ff @(posedge aclk)
	begin
		if (!aresetn || !run)
		begin
			cnt <= 14'h0000;
			tick <= 1'b0;
		end
		else if (ce)
		begin
			tick <= (cnt == last);
			cnt <= (cnt == last) ? 14'h0000 : cnt + 14'h0001;
		end
	end
endmodule
`default_nettype wire

// ===== hw/ast_core.sv
// Asynchronous serial transceiver with AXI4-Lite registers.
// Assumes one clock; rx_pin is asynchronous and synchronised here.
`timescale 1ns/10ps
`default_nettype none
// How it works
// - Odd-parity select picks even at 0, odd at 1, for both directions.
// - With parity on, top data position carries parity; mismatch flags it.
// - Nine-bit and parity select give 8, 7+p, 9 or 8+p bits.
// - Holding word waits while shifter sends; line driven while active.
// - Open-drain select releases the line for ones instead of driving.
// - Empty flag clears on accepted write, sets when word enters shifter.
// - Complete flag low while busy; status read then data write clears it.
// - Enabling transmitter sends one idle preamble after current frame.
// - Break frames repeat while set, then one mark bit, then complete flag.
// - All sent with enable on: both flags set, line held at one.
// - Disable finishes current frame, discards buffer, releases line.
// - Interrupt from empty, complete, full and idle under their enables.
// - Stop bit moves shifter into holding word and sets full flag.
// - Noise, parity, framing flags set only on transfer to holding word.
// - Full flag still set on arrival: overrun, holding kept, no errors.
// - Status read arms clearing; data read clears armed receive flags.
// - Idle is ones for a frame; long type counts only after stop.
// - Idle flag sets once, then not again until a frame is received.
// - Sleep hides receive flags; wake method picks idle or address mark.
// - Idle-line wake clears sleep; next frame received normally.
// - Frame with top bit set clears sleep and is received normally.
// - Loopback feeds transmit bits to receiver and holds line idle while transmitter owns it; off, the port level and direction drive it.
// - Bit rate is clock over 32 times divisor; zero stops it.
// - Receiver samples at 16x and resynchronises on start edges.
// - Frame is zero start, data LSB first, one-level stop.
module ast_core (
	input wire logic aclk, // System clock, 25 MHz
	input wire logic aresetn, // Synchronous reset, low
	input wire logic ce, // Clock enable
	input wire logic [3:0] s_axi_awaddr, // Write address
	input wire logic s_axi_awvalid, // Write address valid
	output logic s_axi_awready, // Write address ready
	input wire logic [31:0] s_axi_wdata, // Write data
	input wire logic [3:0] s_axi_wstrb, // Write strobes
	input wire logic s_axi_wvalid, // Write data valid
	output logic s_axi_wready, // Write data ready
	output logic [1:0] s_axi_bresp, // Write response
	output logic s_axi_bvalid, // Write response valid
	input wire logic s_axi_bready, // Write response ready
	input wire logic [3:0] s_axi_araddr, // Read address
	input wire logic s_axi_arvalid, // Read address valid
	output logic s_axi_arready, // Read address ready
	output logic [31:0] s_axi_rdata, // Read data
	output logic [1:0] s_axi_rresp, // Read response
	output logic s_axi_rvalid, // Read data valid
	input wire logic s_axi_rready, // Read data ready
	input wire logic rx_pin, // Serial receive line
	output logic tx_out, // Transmit line level
	output logic tx_oe_n, // Transmit enable, low drives
	input wire logic port_pin7_level, // Port level when released
	input wire logic port_direction_out, // Port drives when released
	output logic irq // Interrupt request
);
	logic [12:0] baud_divisor;
	logic [ast_pkg::CTL1_W-1:0] ctl;
	logic [ast_pkg::STAT_W-1:0] stat;
	logic [ast_pkg::STAT_W-1:0] armed;
	logic [8:0] tx_holding_reg;
	logic [8:0] rx_holding_reg;
	logic rx_sync;
	logic tick;
	ast_pkg::ast_tx_type tx_state;
	logic [10:0] tx_sh;
	logic [3:0] tx_left;
	logic [3:0] tx_sub;
	logic te_q;
	logic pre_pend;
	logic brk_done;
	ast_pkg::ast_rx_type rx_state;
	logic [3:0] rx_sub;
	logic [3:0] rx_cnt;
	logic [8:0] rx_sh;
	logic [1:0] smp;
	logic rx_noise;
	logic [7:0] one_cnt;
	logic idle_block;

	ast_tick_sync u_sync (
		.aclk(aclk),
		.aresetn(aresetn),
		.ce(ce),
		.rx_pin(rx_pin),
		.baud_divisor(baud_divisor),
		.rx_sync(rx_sync),
		.tick(tick)
	);

	// ------------------------------------------------------------
	// Bus decode
	// ------------------------------------------------------------
	wire wr_go = s_axi_awvalid && s_axi_wvalid && !s_axi_awready
		&& !s_axi_bvalid;
	wire wr_do = ce && s_axi_awready;
	wire rd_do = ce && s_axi_arready;
	wire wr_ctl0 = wr_do && s_axi_awaddr == ast_pkg::OFS_CTL0;
	wire wr_ctl1 = wr_do && s_axi_awaddr == ast_pkg::OFS_CTL1;
	wire wr_data = wr_do && s_axi_awaddr == ast_pkg::OFS_DATA;
	wire rd_stat = rd_do && s_axi_araddr == ast_pkg::OFS_STAT;
	wire rd_data = rd_do && s_axi_araddr == ast_pkg::OFS_DATA;
	wire wr_map = s_axi_awaddr[1:0] == 2'h0;
	wire rd_map = s_axi_araddr[1:0] == 2'h0;

	// Named control fields
	wire te = ctl[ast_pkg::C_TE];
	wire re = ctl[ast_pkg::C_RE];
	wire pe = ctl[ast_pkg::C_PE];
	wire podd = ctl[ast_pkg::C_PODD];
	wire nine = ctl[ast_pkg::C_NINE];
	wire sleep = ctl[ast_pkg::C_SLEEP];
	wire loop = ctl[ast_pkg::C_LOOP];
	wire od = ctl[ast_pkg::C_OD];

	// ------------------------------------------------------------
	// Transmit frame assembly
	// ------------------------------------------------------------
	wire [8:0] tx_d = nine ? tx_holding_reg : {1'b1, tx_holding_reg[7:0]};
	wire tx_par = (nine ? ^tx_holding_reg[7:0] : ^tx_holding_reg[6:0])
		^ podd;
	wire [8:0] tx_w = !pe ? tx_d : nine ? {tx_par, tx_d[7:0]}
		: {1'b1, tx_par, tx_d[6:0]};
	wire [10:0] tx_frame = {1'b1, tx_w, 1'b0};
	wire [3:0] flen = nine ? ast_pkg::LEN11 : ast_pkg::LEN10;
	wire tx_bit = (tx_state == ast_pkg::TX_SHIFT) ? tx_sh[0] : 1'b1;
	wire tx_end = tx_sub == ast_pkg::SUB_LAST && tx_left == 4'h1;
	wire tx_pick = tick && (tx_state != ast_pkg::TX_SHIFT || tx_end);
	wire data_ok = !stat[ast_pkg::S_TX_BUFFER_EMPTY_FLAG] || armed[ast_pkg::S_TX_BUFFER_EMPTY_FLAG];
	wire tx_load = tx_pick && te && !pre_pend && !ctl[ast_pkg::C_BRK]
		&& !brk_done && !stat[ast_pkg::S_TX_BUFFER_EMPTY_FLAG];

	// ------------------------------------------------------------
	// Receive decode
	// ------------------------------------------------------------
	wire rx_in = loop ? tx_bit : rx_sync;
	// Third vote is the live line at the centre sample
	wire maj = (smp[0] & smp[1]) | (smp[0] & rx_in) | (smp[1] & rx_in);
	wire mid = tick && rx_sub == ast_pkg::SMP_C;
	wire [3:0] nbits = nine ? 4'h9 : 4'h8;
	wire rx_fin = mid && rx_state == ast_pkg::RX_BITS && rx_cnt == nbits;
	wire [8:0] rx_w = nine ? rx_sh : {1'b0, rx_sh[8:1]};
	wire rx_msb = nine ? rx_w[8] : rx_w[7];
	wire rx_pbad = pe && ((nine ? ^rx_w[8:0] : ^rx_w[7:0]) ^ podd);
	wire rx_wake = sleep && ctl[ast_pkg::C_WMARK] && rx_msb;
	wire rx_take = rx_fin && re && (!sleep || rx_wake);
	wire rx_ok = rx_take && !stat[ast_pkg::S_RX_BUFFER_FULL_FLAG];
	wire rx_ovr = rx_take && stat[ast_pkg::S_RX_BUFFER_FULL_FLAG];
	wire [7:0] idle_t = nine ? ast_pkg::IDLE_T11 : ast_pkg::IDLE_T10;
	wire idle_hold = ctl[ast_pkg::C_ILONG]
		&& rx_state != ast_pkg::RX_WAIT;
	wire idle_ev = tick && rx_in && !idle_hold
		&& one_cnt == idle_t - 8'h01;
	wire idle_wake = idle_ev && sleep && !ctl[ast_pkg::C_WMARK];
	wire idle_set = idle_ev && !sleep && !idle_block;

	// ------------------------------------------------------------
	// Bus handshake flops
	// ------------------------------------------------------------
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= ast_pkg::RESP_OK;
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rresp <= ast_pkg::RESP_OK;
		end
		else if (ce)
		begin
			s_axi_awready <= wr_go;
			s_axi_wready <= wr_go;
			if (s_axi_awready)
			begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= wr_map ? ast_pkg::RESP_OK : ast_pkg::RESP_ERR;
			end
			else if (s_axi_bready)
				s_axi_bvalid <= 1'b0;
			s_axi_arready <= s_axi_arvalid && !s_axi_arready
				&& !s_axi_rvalid;
			if (s_axi_arready)
			begin
				s_axi_rvalid <= 1'b1;
				s_axi_rresp <= rd_map ? ast_pkg::RESP_OK : ast_pkg::RESP_ERR;
			end
			else if (s_axi_rready)
				s_axi_rvalid <= 1'b0;
		end
	end

	// Read data latched at the address handshake
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			s_axi_rdata <= 32'h00000000;
		else if (rd_do)
		begin
			case (s_axi_araddr)
				ast_pkg::OFS_CTL0: s_axi_rdata <= {19'h00000, baud_divisor};
				ast_pkg::OFS_CTL1: s_axi_rdata <= {17'h00000, ctl};
				ast_pkg::OFS_STAT: s_axi_rdata <= {24'h000000, stat};
				ast_pkg::OFS_DATA: s_axi_rdata <= {23'h000000, rx_holding_reg};
				default: s_axi_rdata <= 32'h00000000;
			endcase
		end
	end

	// ------------------------------------------------------------
	// Control registers; hardware wake clears sleep
	// ------------------------------------------------------------
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			baud_divisor <= ast_pkg::CTL0_RST;
			ctl <= ast_pkg::CTL1_RST;
		end
		else if (ce)
		begin
			if (wr_ctl0 && s_axi_wstrb[0])
				baud_divisor[7:0] <= s_axi_wdata[7:0];
			if (wr_ctl0 && s_axi_wstrb[1])
				baud_divisor[12:8] <= s_axi_wdata[12:8];
			if (wr_ctl1 && s_axi_wstrb[0])
				ctl[7:0] <= s_axi_wdata[7:0];
			else if (rx_take || idle_wake)
				ctl[ast_pkg::C_SLEEP] <= 1'b0;
			if (wr_ctl1 && s_axi_wstrb[1])
				ctl[14:8] <= s_axi_wdata[14:8];
		end
	end

	// ------------------------------------------------------------
	// Status flags: a set in the same cycle beats a clear
	// ------------------------------------------------------------
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			stat <= 8'h00;
			stat[ast_pkg::S_TX_BUFFER_EMPTY_FLAG] <= 1'b1;
			stat[ast_pkg::S_TC] <= 1'b1;
			armed <= 8'h00;
			tx_holding_reg <= 9'h000;
			rx_holding_reg <= 9'h000;
			idle_block <= 1'b0;
		end
		else if (ce)
		begin
			if (rd_stat)
				armed <= stat;
			else if (rd_data)
				armed[5:0] <= 6'h00;
			if (wr_data && data_ok)
			begin
				tx_holding_reg <= s_axi_wdata[8:0];
				stat[ast_pkg::S_TX_BUFFER_EMPTY_FLAG] <= 1'b0;
				armed[ast_pkg::S_TX_BUFFER_EMPTY_FLAG] <= 1'b0;
			end
			if (wr_data && armed[ast_pkg::S_TC])
			begin
				stat[ast_pkg::S_TC] <= 1'b0;
				armed[ast_pkg::S_TC] <= 1'b0;
			end
			if (rd_data)
				stat[5:0] <= stat[5:0] & ~armed[5:0];
			if (tx_pick && tx_state == ast_pkg::TX_SHIFT)
				stat[ast_pkg::S_TC] <= 1'b0;
			if (tx_pick && tx_state == ast_pkg::TX_SHIFT && !te)
				stat[ast_pkg::S_TC] <= 1'b1;
			if (tx_pick && te && tx_state != ast_pkg::TX_SHIFT)
				stat[ast_pkg::S_TC] <= 1'b0;
			if (tx_pick && te && !pre_pend && !ctl[ast_pkg::C_BRK]
				&& !brk_done && stat[ast_pkg::S_TX_BUFFER_EMPTY_FLAG])
				stat[ast_pkg::S_TC] <= 1'b1;
			if (tx_load || (tx_pick && !te))
				stat[ast_pkg::S_TX_BUFFER_EMPTY_FLAG] <= 1'b1;
			if (rx_ok)
			begin
				rx_holding_reg <= rx_w;
				stat[ast_pkg::S_RX_BUFFER_FULL_FLAG] <= 1'b1;
				stat[ast_pkg::S_FE] <= !maj;
				stat[ast_pkg::S_NF] <= rx_noise | (smp[0] ^ smp[1])
					| (smp[1] ^ rx_in);
				stat[ast_pkg::S_PF] <= rx_pbad;
				idle_block <= 1'b0;
			end
			if (rx_ovr)
				stat[ast_pkg::S_OR] <= 1'b1;
			if (idle_set)
			begin
				stat[ast_pkg::S_IDLE] <= 1'b1;
				idle_block <= 1'b1;
			end
		end
	end

	// ------------------------------------------------------------
	// Transmit sequencer
	// ------------------------------------------------------------
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			tx_state <= ast_pkg::TX_OFF;
			tx_sh <= 11'h7ff;
			tx_left <= 4'h0;
			tx_sub <= 4'h0;
			te_q <= 1'b0;
			pre_pend <= 1'b0;
			brk_done <= 1'b0;
		end
		else if (ce)
		begin
			te_q <= te;
			if (te && !te_q)
				pre_pend <= 1'b1;
			if (tick && tx_state == ast_pkg::TX_SHIFT && !tx_end)
			begin
				tx_sub <= tx_sub + 4'h1;
				if (tx_sub == ast_pkg::SUB_LAST)
				begin
					tx_sh <= {1'b1, tx_sh[10:1]};
					tx_left <= tx_left - 4'h1;
				end
			end
			if (tx_pick)
			begin
				tx_sub <= 4'h0;
				tx_left <= flen;
				tx_state <= ast_pkg::TX_SHIFT;
				if (!te)
				begin
					tx_state <= ast_pkg::TX_OFF;
					pre_pend <= 1'b0;
					brk_done <= 1'b0;
				end
				else if (pre_pend)
				begin
					tx_sh <= 11'h7ff;
					pre_pend <= 1'b0;
				end
				else if (ctl[ast_pkg::C_BRK])
				begin
					tx_sh <= 11'h000;
					brk_done <= 1'b1;
				end
				else if (brk_done)
				begin
					tx_sh <= 11'h7ff;
					tx_left <= 4'h1;
					brk_done <= 1'b0;
				end
				else if (!stat[ast_pkg::S_TX_BUFFER_EMPTY_FLAG])
					tx_sh <= tx_frame;
				else
					tx_state <= ast_pkg::TX_MARK;
			end
		end
	end

	// ------------------------------------------------------------
	// Pin and interrupt outputs
	// ------------------------------------------------------------
	wire tx_own = tx_state != ast_pkg::TX_OFF;
	wire pin_lvl = tx_own ? (loop | tx_bit) : port_pin7_level;
	wire pin_drv = tx_own || port_direction_out;
	wire irq_next = (ctl[ast_pkg::C_TIE] && stat[ast_pkg::S_TX_BUFFER_EMPTY_FLAG])
		|| (ctl[ast_pkg::C_TX_DONE_IRQ_EN] && stat[ast_pkg::S_TC])
		|| (!sleep && ctl[ast_pkg::C_RIE] && stat[ast_pkg::S_RX_BUFFER_FULL_FLAG])
		|| (!sleep && ctl[ast_pkg::C_IDLE_IRQ_EN] && stat[ast_pkg::S_IDLE]);
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			tx_out <= 1'b1;
			tx_oe_n <= 1'b1;
			irq <= 1'b0;
		end
		else if (ce)
		begin
			tx_out <= od ? 1'b0 : pin_lvl;
			tx_oe_n <= !(pin_drv && !(od && pin_lvl));
			irq <= irq_next;
		end
	end

	// ------------------------------------------------------------
	// Receive bit processor at 16 ticks per bit
	// ------------------------------------------------------------
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			rx_state <= ast_pkg::RX_WAIT;
			rx_sub <= 4'h0;
			rx_cnt <= 4'h0;
			rx_sh <= 9'h000;
			smp <= 2'h3;
			rx_noise <= 1'b0;
		end
		else if (ce && tick)
		begin
			rx_sub <= rx_sub + 4'h1;
			if (rx_sub == ast_pkg::SMP_A)
				smp[0] <= rx_in;
			if (rx_sub == ast_pkg::SMP_B)
				smp[1] <= rx_in;
			case (rx_state)
				ast_pkg::RX_WAIT:
				begin
					rx_sub <= 4'h1;
					rx_cnt <= 4'h0;
					rx_noise <= 1'b0;
					if (!rx_in)
						rx_state <= ast_pkg::RX_START;
				end
				ast_pkg::RX_START:
					if (rx_sub == ast_pkg::SMP_C && (maj | rx_in))
						rx_state <= ast_pkg::RX_WAIT;
					else if (rx_sub == ast_pkg::SUB_LAST)
						rx_state <= ast_pkg::RX_BITS;
				ast_pkg::RX_BITS:
					if (rx_sub == ast_pkg::SMP_C)
					begin
						if (rx_cnt == nbits)
							rx_state <= ast_pkg::RX_WAIT;
						else
						begin
							rx_sh <= {maj, rx_sh[8:1]};
							rx_cnt <= rx_cnt + 4'h1;
							rx_noise <= rx_noise | (smp[0] ^ smp[1])
								| (smp[1] ^ rx_in);
						end
					end
				default:
					rx_state <= ast_pkg::RX_WAIT;
			endcase
		end
	end

	// ------------------------------------------------------------
	// Idle-line counter of one-level samples
	// ------------------------------------------------------------
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			one_cnt <= 8'h00;
		else if (ce && tick)
		begin
			if (!rx_in || idle_hold)
				one_cnt <= 8'h00;
			else if (one_cnt != idle_t)
				one_cnt <= one_cnt + 8'h01;
		end
	end
endmodule
`default_nettype wire

// ===== verif/ast_assertions.sv
// Port checker for the serial transceiver core.
// Assumes control words are written as whole words.
`timescale 1ns/10ps
`default_nettype none
module ast_assertions (
	input wire logic aclk, // Clock
	input wire logic aresetn, // Reset, low
	input wire logic [3:0] s_axi_awaddr, // Write address
	input wire logic s_axi_awvalid, // Address valid
	input wire logic s_axi_awready, // Address ready
	input wire logic [31:0] s_axi_wdata, // Write data
	input wire logic s_axi_wvalid, // Data valid
	input wire logic s_axi_wready, // Data ready
	input wire logic s_axi_bvalid, // Response valid
	input wire logic s_axi_arvalid, // Read valid
	input wire logic s_axi_arready, // Read ready
	input wire logic s_axi_rvalid, // Read data valid
	input wire logic tx_out, // Line level
	input wire logic tx_oe_n, // Line enable, low
	input wire logic irq // Interrupt
);
	// ------
	// Shadow of divisor and control
	// ------
	logic [12:0] div_q;
	logic [14:0] ctl_q;
	logic [15:0] lo_cnt;
	wire lvl = tx_oe_n | tx_out;
	wire wr_go = s_axi_awvalid & s_axi_awready & s_axi_wvalid;
	wire wr_c0 = wr_go && s_axi_awaddr == ast_pkg::OFS_CTL0;
	wire wr_c1 = wr_go && s_axi_awaddr == ast_pkg::OFS_CTL1;
	// Capture writes, count low cycles
	always_ff @(posedge aclk)
	begin
		div_q <= !aresetn ? 13'h0000 : wr_c0 ? s_axi_wdata[12:0] : div_q;
		ctl_q <= !aresetn ? 15'h0000 : wr_c1 ? s_axi_wdata[14:0] : ctl_q;
		lo_cnt <= (lvl || !aresetn) ? 16'h0000 : lo_cnt + 16'h0001;
	end
	// ------
	// Properties
	// ------
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	sequence s_hi8;
		lvl [*8];
	endsequence
	a_low_whole: assert property (
		$rose(lvl) && div_q != 0 |-> lo_cnt % {div_q, 5'h00} == 0)
		else $error("low run not whole bits");
	a_preamble_idle: assert property (
		$rose(ctl_q[0]) && tx_oe_n && !ctl_q[10]
		|-> ##4 s_hi8 ##1 s_hi8 ##200 lvl)
		else $error("no idle preamble");
	a_od_low: assert property (
		ctl_q[10] && $past(ctl_q[10], 2) |-> tx_oe_n || !tx_out)
		else $error("open drain drove high");
	a_loop_idle: assert property (
		ctl_q[9] && $past(ctl_q[9], 2) |-> lvl)
		else $error("line not idle in loop");
	a_irq_quiet: assert property (
		ctl_q[14:11] == 4'h0 && $past(ctl_q[14:11], 2) == 4'h0 |-> !irq)
		else $error("irq without enable");
	a_aw_pair: assert property (s_axi_awready == s_axi_wready)
		else $error("address and data ready split");
	a_wr_answer: assert property (s_axi_awready |=> s_axi_bvalid)
		else $error("late write response");
	a_rd_answer: assert property (
		s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("late read data");
endmodule
bind ast_core ast_assertions u_chk (.*);
`default_nettype wire

// ===== verif/ast_remote.sv
// Remote serial device on the far side of both lines.
// Assumes divisor 1, so a bit lasts 32 clocks.
`timescale 1ns/10ps
`default_nettype none
module ast_remote (
	input wire logic aclk, // Clock
	input wire logic line, // Device transmit wire
	output logic rx_pin // Device receive wire
);
	localparam int BT = 32; // Clocks per bit
	logic [7:0] got [$];
	logic [7:0] d;
	initial rx_pin = 1'b1;
	// One bit-time of a level
	task automatic put(input logic b);
		@(posedge aclk);
		rx_pin <= b;
		repeat (BT - 1) @(posedge aclk);
	endtask
	// Start, data LSB first, stop, then one idle bit
	task automatic send(input logic [8:0] w, input int n, input logic s);
		put(1'b0);
		for (int i = 0; i < n; i++)
			put(w[i]);
		put(s);
		put(1'b1);
	endtask
	// Sample incoming frames at bit centres
	always
	begin
		@(negedge line);
		repeat (BT / 2) @(posedge aclk);
		for (int i = 0; i < 8; i++)
		begin
			repeat (BT) @(posedge aclk);
			d[i] = line;
		end
		repeat (BT) @(posedge aclk);
		got.push_back(d);
		wait (line === 1'b1);
	end
endmodule
`default_nettype wire

// ===== verif/tb.sv
// Self-checking bench for the serial transceiver.
// Assumes divisor 1 and a pulled-up transmit wire.
`timescale 1ns/10ps
`default_nettype none
module tb;
	localparam logic [3:0] ST = ast_pkg::OFS_STAT;
	localparam logic [3:0] DA = ast_pkg::OFS_DATA;
	localparam logic [3:0] C1 = ast_pkg::OFS_CTL1;
	logic aclk = 1'b0, aresetn = 1'b0, ce = 1'b1;
	logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0;
	logic [3:0] s_axi_wstrb = 4'hf;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, v;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
	logic s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
	logic s_axi_rready = 1'b0, port_pin7_level = 1'b0;
	logic port_direction_out = 1'b0, rx_pin, tx_out, tx_oe_n, irq;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid;
	logic s_axi_arready, s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
	logic [14:0] txc [4] = '{15'h001, 15'h401, 15'h005, 15'h00d};
	logic [7:0] txe [4] = '{8'hb5, 8'hb5, 8'h35, 8'hb5};
	logic [14:0] rxc [4] = '{15'h002, 15'h006, 15'h002, 15'h012};
	logic [8:0] rxd [4] = '{9'h03c, 9'h0b5, 9'h055, 9'h1a5};
	logic [8:0] rxm [4] = '{9'h0ff, 9'h07f, 9'h0ff, 9'h1ff};
	logic [7:0] rxs [4] = '{8'h20, 8'h21, 8'h22, 8'h20};
	int n_errors = 0;
	int checks = 0;
	wire line = tx_oe_n ? 1'b1 : tx_out;
	always #20 aclk = ~aclk;
	ast_core dut (.*);
	ast_remote u_rem (.aclk(aclk), .line(line), .rx_pin(rx_pin));
	// ------
	// Compare, verdict and bus tasks
	// ------
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		checks++;
		if (g !== e)
		begin
			n_errors++;
			$display("[FAIL] %0t got %h want %h", $time, g, e);
		end
	endtask
	task automatic results;
		$display("checks %0d errors %0d", checks, n_errors);
		if (n_errors == 0 && checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic tmo(input int n);
		if (n >= 400)
		begin
			n_errors++;
			$display("[FAIL] %0t bus wait expired", $time);
			results;
		end
	endtask
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		int n;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		for (n = 0; n < 400 && s_axi_awready !== 1'b1; n++)
			@(posedge aclk);
		s_axi_awvalid <= 1'b0;
		s_axi_wvalid <= 1'b0;
		for (; n < 400 && s_axi_bvalid !== 1'b1; n++)
			@(posedge aclk);
		rsp = s_axi_bresp;
		s_axi_bready <= 1'b0;
		tmo(n);
	endtask
	task automatic rd(input logic [3:0] a, output logic [31:0] d);
		int n;
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		for (n = 0; n < 400 && s_axi_arready !== 1'b1; n++)
			@(posedge aclk);
		s_axi_arvalid <= 1'b0;
		for (; n < 400 && s_axi_rvalid !== 1'b1; n++)
			@(posedge aclk);
		d = s_axi_rdata;
		rsp = s_axi_rresp;
		s_axi_rready <= 1'b0;
		tmo(n);
	endtask
	task automatic bits(input int k);
		repeat (k * 32) @(posedge aclk);
	endtask
	// ------
	// Test sequence
	// ------
	initial
	begin
		repeat (4) @(posedge aclk);
		aresetn <= 1'b1;
		rd(ST, v);
		chk(v, 32'hc0);
		rd(4'h2, v);
		chk({30'h0, rsp}, 32'h2);
		wr(4'h6, 32'h0);
		chk({30'h0, rsp}, 32'h2);
		wr(ast_pkg::OFS_CTL0, 32'h1);
		chk({30'h0, rsp}, 32'h0);
		for (int i = 0; i < 4; i++)
		begin
			wr(C1, {17'h0, txc[i]});
			rd(ST, v);
			wr(DA, 32'hb5);
			rd(ST, v);
			if (i == 0)
				chk(v & 32'hc0, 32'h0);
			bits(23);
			chk({24'h0, u_rem.got.pop_front()}, {24'h0, txe[i]});
			rd(ST, v);
			chk(v & 32'hc0, 32'hc0);
		end
		$display("transmit test done");
		for (int i = 0; i < 4; i++)
		begin
			wr(C1, {17'h0, rxc[i]});
			u_rem.send(rxd[i], 8 + (i / 3), !rxs[i][1]);
			rd(ST, v);
			chk(v & 32'h2f, {24'h0, rxs[i]});
			rd(DA, v);
			chk(v & {23'h0, rxm[i]}, {23'h0, rxd[i] & rxm[i]});
			rd(ST, v);
			chk(v & 32'h2f, 32'h0);
		end
		u_rem.send(9'h011, 9, 1'b1);
		u_rem.send(9'h022, 9, 1'b1);
		rd(ST, v);
		chk(v & 32'h2f, 32'h28);
		rd(DA, v);
		chk(v, 32'h11);
		bits(12);
		rd(ST, v);
		chk(v & 32'h10, 32'h10);
		rd(DA, v);
		bits(12);
		rd(ST, v);
		chk(v & 32'h10, 32'h0);
		$display("receive test done");
		wr(C1, 32'h0c2);
		u_rem.send(9'h005, 8, 1'b1);
		rd(ST, v);
		chk(v & 32'h20, 32'h0);
		u_rem.send(9'h085, 8, 1'b1);
		rd(C1, v);
		chk(v & 32'h80, 32'h0);
		rd(ST, v);
		rd(DA, v);
		chk(v, 32'h85);
		$display("wake test done");
		wr(C1, 32'h203);
		rd(ST, v);
		wr(DA, 32'h5a);
		bits(24);
		rd(DA, v);
		chk(v, 32'h5a);
		chk(32'(u_rem.got.size()), 32'h0);
		wr(C1, 32'h803);
		bits(1);
		chk({31'h0, irq}, 32'h1);
		wr(C1, 32'h103);
		bits(12);
		wr(C1, 32'h003);
		bits(24);
		chk({31'h0, irq}, 32'h0);
		chk(32'(u_rem.got.size()), 32'h1);
		chk({24'h0, u_rem.got.pop_front()}, 32'h0);
		$display("loop and break test done");
		results;
	end
endmodule
`default_nettype wire
